// ### verilog/lfc_top.sv
/*
  LED fade and toggle controller core. Debounces an active-low button,
  toggles the channel, runs gamma fade ramps, passes an external PWM
  level when the button has not lit the channel, and cuts the current
  on a qualified output short.
  Assumes all inputs are synchronous to mclk and the fade settings are
  static numbers of clock cycles per step (zero selects instant mode).
*/
`default_nettype none
module lfc_top #(
    // Button debounce length in clock cycles; defaults to the 37 ms figure.
    parameter int unsigned DEB_CYC = lfc_pkg::DEBOUNCE_CYC
) (
    // Clock and reset.
    input  wire logic                       mclk,
    input  wire logic                       arst_n,
    // Button, active low while pressed.
    input  wire logic                       button_n,
    // External PWM level and its activity flag.
    input  wire logic                       pwm_in,
    input  wire logic                       pwm_active,
    // Settings.
    input  wire logic [lfc_pkg::FADE_W-1:0] fade_in_time_setting,
    input  wire logic [lfc_pkg::FADE_W-1:0] fade_out_time_setting,
    input  wire logic [lfc_pkg::CUR_W-1:0]  full_scale_current_setting,
    // Short comparator, high while output is below short_detect_threshold.
    input  wire logic                       short_below,
    // Current source drive.
    output logic [lfc_pkg::CUR_W-1:0]       current_code,
    output logic                            channel_on,
    output logic                            short_fault
);
    import lfc_pkg::*;

    // Ramp states, one-hot.
    typedef enum logic [2:0] {
        LFC_IDLE = 3'h1,
        LFC_UP   = 3'h2,
        LFC_DOWN = 3'h4
    } lfc_state_t;

    logic                btn_q;          // Debounced button level.
    logic                btn_prev_r;     // Previous debounced level.
    logic                btn_prev_nxt;   // Next previous level.
    logic                press;          // One-cycle qualified press.
    logic                short_q;        // Qualified short level.
    lfc_state_t          state_r;        // Ramp state.
    lfc_state_t          state_nxt;      // Next ramp state.
    logic                on_r;           // Channel latched on by button.
    logic                on_nxt;         // Next latch value.
    logic [STEP_W-1:0]   step_r;         // Present gamma step.
    logic [STEP_W-1:0]   step_nxt;       // Next step.
    logic [FADE_W-1:0]   tick_r;         // Cycles spent on this step.
    logic [FADE_W-1:0]   tick_nxt;       // Next tick count.
    logic [FADE_W-1:0]   step_len;       // Cycles per step for this ramp.
    logic [CUR_W-1:0]    code_r;         // Registered current code.
    logic [CUR_W-1:0]    code_nxt;       // Next current code.
    logic [CUR_W-1:0]    base_code;      // Code before short reduction.
    logic [15:0]         scaled;         // Gamma level times full scale.
    logic [CUR_W-1:0]    ramp_code;      // Ramp contribution.

    // Button debouncer, applied to both edges.
    lfc_qualify #(.COUNT(DEB_CYC)) u_btn (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .raw_in   (button_n),
        .qual_out (btn_q)
    );

    // Short qualifier; sense is inverted so idle maps to the rest level.
    logic short_n_q; // Qualified short, active low.
    lfc_qualify #(.COUNT(SHORT_QUAL_CYC)) u_short (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .raw_in   (~short_below),
        .qual_out (short_n_q)
    );
    assign short_q = ~short_n_q;

    // A press is the debounced falling edge; one press gives one pulse.
    assign press = btn_prev_r & ~btn_q;

    // Cycles per step: zero setting selects the instant rate.
    always_comb begin
        if (state_r == LFC_DOWN) begin
            step_len = (fade_out_time_setting == '0) ? FADE_W'(INSTANT_STEP_CYC) : fade_out_time_setting;
        end else begin
            step_len = (fade_in_time_setting == '0) ? FADE_W'(INSTANT_STEP_CYC) : fade_in_time_setting;
        end
    end

    // Toggle and ramp control.
    always_comb begin
        state_nxt    = state_r;
        on_nxt       = on_r;
        step_nxt     = step_r;
        tick_nxt     = tick_r;
        btn_prev_nxt = btn_q;
        if (press) begin
            // Toggle from the present state, regardless of PWM.
            on_nxt   = ~on_r;
            tick_nxt = '0;
            // Reverse from the present step, keeping current continuous.
            state_nxt = on_r ? LFC_DOWN : LFC_UP;
        end else begin
            case (state_r)
                LFC_IDLE: begin
                    tick_nxt = '0;
                end
                LFC_UP, LFC_DOWN: begin
                    // Walk the 63 gamma steps at the chosen rate.
                    if (tick_r >= step_len - 1'b1) begin
                        tick_nxt = '0;
                        if (state_r == LFC_UP) begin
                            if (step_r == STEP_MAX) begin
                                state_nxt = LFC_IDLE;
                            end else begin
                                step_nxt = step_r + 1'b1;
                            end
                        end else begin
                            if (step_r == '0) begin
                                state_nxt = LFC_IDLE;
                            end else begin
                                step_nxt = step_r - 1'b1;
                            end
                        end
                    end else begin
                        tick_nxt = tick_r + 1'b1;
                    end
                end
                default: begin
                    state_nxt = LFC_IDLE;
                end
            endcase
        end
    end

    // Current code selection.
    always_comb begin
        scaled    = 16'(lfc_gamma(step_r)) * 16'(full_scale_current_setting);
        ramp_code = scaled[15:8] + ((step_r == STEP_MAX) ? full_scale_current_setting - scaled[15:8] : '0);
        if (on_r || state_r != LFC_IDLE || !pwm_active) begin
            // Button owns the channel, or fades down; PWM ignored.
            base_code = ramp_code;
        end else begin
            // PWM level gates full scale; average follows duty.
            base_code = pwm_in ? full_scale_current_setting : '0;
        end
        // Short cuts to a fifth and recovers when it clears.
        code_nxt = short_q ? CUR_W'(base_code / CUR_W'(SHORT_DIV)) : base_code;
    end

    // Register control state and the output code.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_r    <= LFC_IDLE;
            on_r       <= 1'b0;
            step_r     <= '0;
            tick_r     <= '0;
            btn_prev_r <= 1'b1;
            code_r     <= '0;
        end else begin
            state_r    <= state_nxt;
            on_r       <= on_nxt;
            step_r     <= step_nxt;
            tick_r     <= tick_nxt;
            btn_prev_r <= btn_prev_nxt;
            code_r     <= code_nxt;
        end
    end

    assign current_code = code_r;
    assign channel_on   = on_r;
    assign short_fault  = short_q;

    // A press flips the channel latch on the next edge.
    a_press_toggle: assert property (@(posedge mclk) disable iff (!arst_n)
        press |=> (on_r != $past(on_r))) else $error("press did not toggle channel");

    // Without a press the latch holds.
    a_latch_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        !press |=> (on_r == $past(on_r))) else $error("channel changed without press");

    // Turning on starts an up ramp.
    a_on_ramps_up: assert property (@(posedge mclk) disable iff (!arst_n)
        (press && !on_r) |=> (state_r == LFC_UP)) else $error("on press did not ramp up");

    // A reversal keeps the step index.
    a_reverse_step: assert property (@(posedge mclk) disable iff (!arst_n)
        press |=> (step_r == $past(step_r))) else $error("reversal jumped step");

    // Step moves at most by one per cycle.
    a_step_single: assert property (@(posedge mclk) disable iff (!arst_n)
        (step_r != $past(step_r)) |-> ((step_r - $past(step_r) == 6'h01) || ($past(step_r) - step_r == 6'h01)))
        else $error("step skipped");

    // PWM passes straight when the button is idle and off.
    sequence s_pwm_owner;
        !on_r && state_r == LFC_IDLE && pwm_active && !short_q;
    endsequence
    a_pwm_pass: assert property (@(posedge mclk) disable iff (!arst_n)
        s_pwm_owner |=> (current_code == ($past(pwm_in) ? $past(full_scale_current_setting) : 8'h00)))
        else $error("pwm level not passed");

    // PWM is ignored once the button lit the channel.
    a_pwm_ignored: assert property (@(posedge mclk) disable iff (!arst_n)
        (on_r && state_r == LFC_IDLE && !short_q && !press) |=> (current_code == $past(full_scale_current_setting)))
        else $error("pwm not ignored when on");

    // Short reduces the code to a fifth.
    a_short_cut: assert property (@(posedge mclk) disable iff (!arst_n)
        short_q |=> (current_code <= $past(full_scale_current_setting) / 8'h05)) else $error("short not reduced");
endmodule
`default_nettype wire

// ### pkg/lfc_pkg.sv
/*
  Package for the LED fade and toggle controller: timing counts, ramp
  geometry, current code widths and the gamma table.
  Assumes a 25 MHz core clock; all counts are derived from that rate.
*/
`default_nettype none
package lfc_pkg;
    // Core clock rate in hertz.
    localparam int unsigned CLK_HZ         = 25_000_000;
    // Debounce interval in microseconds, as typical.
    localparam int unsigned DEBOUNCE_US    = 37_000;
    // Debounce interval in clock cycles.
    localparam int unsigned DEBOUNCE_CYC   = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
    // Short qualification time in microseconds (default, not printed).
    localparam int unsigned SHORT_QUAL_US  = 10;
    // Short qualification time in clock cycles.
    localparam int unsigned SHORT_QUAL_CYC = (CLK_HZ / 1_000_000) * SHORT_QUAL_US;
    // Instant transition time when a fade setting is zero, in microseconds.
    localparam int unsigned INSTANT_US     = 70;
    // Whole instant transition in clock cycles (longest time, rounded down).
    localparam int unsigned INSTANT_CYC    = (CLK_HZ / 1_000_000) * INSTANT_US;
    // Number of gamma steps in a ramp.
    localparam int unsigned RAMP_STEPS     = 63;
    // Cycles per step when the fade setting is zero.
    localparam int unsigned INSTANT_STEP_CYC = INSTANT_CYC / RAMP_STEPS;
    // Width of the step index.
    localparam int unsigned STEP_W         = 6;
    // Width of a fade time setting (cycles per step).
    localparam int unsigned FADE_W         = 24;
    // Width of the current code.
    localparam int unsigned CUR_W          = 8;
    // Width of the debounce and qualify counters.
    localparam int unsigned CNT_W          = 24;
    // Reduced current under short, numerator over 5 (20 percent).
    localparam int unsigned SHORT_DIV      = 5;
    // Last step index.
    localparam logic [STEP_W-1:0] STEP_MAX = 6'h3F;

    // Gamma curve: index squared, scaled to about 251 at step 63.
    // The product is formed at 32 bits because a 16-bit product would wrap.
    // The top step itself is forced to full scale by the caller.
    function automatic logic [CUR_W-1:0] lfc_gamma(input logic [STEP_W-1:0] idx);
        logic [15:0] sq;
        sq = 16'(idx) * 16'(idx);
        lfc_gamma = CUR_W'((32'(sq) * 32'h0000_0041) >> 10);
    endfunction
endpackage
`default_nettype wire

// ### verilog/lfc_qualify.sv
/*
  Qualifier: an input level is accepted only after it has held steady
  for the full qualification count. Used for the button and the short
  comparator. Assumes its input is synchronous to mclk.
*/
`default_nettype none
module lfc_qualify #(
    parameter int unsigned COUNT = 4
) (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic arst_n,
    // Raw level to be qualified.
    input  wire logic raw_in,
    // Qualified level.
    output logic      qual_out
);
    import lfc_pkg::*;

    logic [CNT_W-1:0] cnt_r;    // Cycles the raw level has differed.
    logic [CNT_W-1:0] cnt_nxt;  // Next count.
    logic             qual_r;   // Accepted level.
    logic             qual_nxt; // Next accepted level.

    // Count while raw differs from the accepted level; restart on any bounce.
    always_comb begin
        cnt_nxt  = '0;
        qual_nxt = qual_r;
        if (raw_in != qual_r) begin
            if (cnt_r >= CNT_W'(COUNT - 1)) begin
                qual_nxt = raw_in;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    // Register the counter and level; level rests high (released, idle).
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r  <= '0;
            qual_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_nxt;
            qual_r <= qual_nxt;
        end
    end

    assign qual_out = qual_r;
endmodule
`default_nettype wire

// ### verif/lfc_part.sv
/*
  Partner model: a bouncing momentary button and a free-running PWM source.
  Assumes a 25 MHz mclk and a bench that calls settle and sets duty_hi.
*/
`default_nettype none
module lfc_part #(
    parameter int unsigned PWM_PERIOD = 83_334, // 300 Hz at 25 MHz.
    parameter int unsigned DEB_CYC    = lfc_pkg::DEBOUNCE_CYC // Debounce length the button must outlast.
) (
    // Clock.
    input  wire logic mclk,
    // Button, low while pressed, and PWM level.
    output var logic  button_n,
    output var logic  pwm_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import lfc_pkg::*;
    int unsigned duty_hi = 0;  // High cycles in each PWM period.
    int unsigned phase = 0;    // Position inside the period.
    initial button_n = 1'h1;
    initial pwm_in = 1'h0;
    // The PWM level only moves just after a rising edge, as a real source would.
    always @(posedge mclk) begin
        phase <= (phase + 1 >= PWM_PERIOD) ? 0 : phase + 1;
        pwm_in <= (phase < duty_hi);
    end
    // Moves the button to a level through short contact bounces, then holds it.
    task automatic settle(input logic lvl);
        int unsigned k;
        for (int b = 0; b < 3; b++) begin
            k = 1 + $urandom_range(200);
            repeat (k) @(posedge mclk) button_n <= lvl;
            @(posedge mclk) button_n <= ~lvl;
        end
        repeat (DEB_CYC + 100) @(posedge mclk) button_n <= lvl;
    endtask
endmodule
`default_nettype wire

// ### verif/led_fade_toggle_controller_test.sv
/*
  Self-checking bench for the fade and toggle controller.
  Assumes lfc_pkg, lfc_top and the partner model lfc_part are compiled first.
*/
`default_nettype none
module led_fade_toggle_controller_test;
    timeunit 1ns;
    timeprecision 1ns;
    import lfc_pkg::*;
    localparam int unsigned PER = 83_334;  // PWM period in cycles.
    localparam int unsigned DEB = 400;     // Shortened debounce so the run stays short.
    typedef struct {int unsigned kind; logic [7:0] val;} lfc_note_t;
    logic              mclk = 1'h0;
    logic              arst_n = 1'h0;
    logic              pwm_active;
    logic              short_below;
    logic              p;
    logic [FADE_W-1:0] fade_in;
    logic [FADE_W-1:0] fade_out;
    logic [CUR_W-1:0]  fs;
    int unsigned       fin, fout;  // Random slow fade-in and fade-out rates.
    wire               button_n, pwm_in, channel_on, short_fault;
    wire  [CUR_W-1:0]  current_code;
    lfc_note_t         notes[$];
    event              look;
    int unsigned       duty[3] = '{0, PER, 0};
    int unsigned       n_fail = 0, cmp_count = 0, cyc = 0;
    always #20 mclk = ~mclk;
    lfc_part #(.PWM_PERIOD(PER), .DEB_CYC(DEB)) part_u (.mclk(mclk), .button_n(button_n), .pwm_in(pwm_in));
    lfc_top #(.DEB_CYC(DEB)) dut_u (.mclk(mclk), .arst_n(arst_n), .button_n(button_n), .pwm_in(pwm_in),
        .pwm_active(pwm_active),
        .fade_in_time_setting(fade_in), .fade_out_time_setting(fade_out), .full_scale_current_setting(fs),
        .short_below(short_below), .current_code(current_code), .channel_on(channel_on), .short_fault(short_fault));
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Compares a current code.
    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Compares a flag.
    task automatic cmp_flag(input logic got, input logic exp);
        cmp_val({7'h00, got}, {7'h00, exp});
    endtask
    // Files an expectation for the watcher.
    task automatic note(input int unsigned k, input logic [7:0] v);
        notes.push_back('{k, v});
        -> look;
    endtask
    // Waits n edges and steps past them so outputs have settled.
    task automatic tick(input int unsigned n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Waits, bounded, for the channel latch to reach a level.
    task automatic wait_on(input logic v);
        for (int i = 0; i < 20_000 && channel_on !== v; i++) tick(1);
    endtask
    // Watcher: takes the oldest note and compares the output of its kind.
    always @(look) begin
        while (notes.size() > 0) begin
            case (notes[0].kind)
                0: cmp_val(current_code, notes[0].val);
                1: cmp_flag(channel_on, notes[0].val[0]);
                2: cmp_flag(short_fault, notes[0].val[0]);
                default: cmp_flag(current_code > 8'h00 && current_code < fs, 1'h1);
            endcase
            void'(notes.pop_front());
        end
    end
    // Cuts a hang short well past the expected run length.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 90_000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        void'($urandom(32'h2047A18E));
        fin         = 300 + $urandom_range(200);
        fout        = 150 + $urandom_range(100);
        duty[0]     = 50 + $urandom_range(400);
        pwm_active  <= 1'h0;
        short_below <= 1'h0;
        fade_in     <= '0;
        fade_out    <= FADE_W'(fout);
        fs          <= 8'(5 * (10 + $urandom_range(40)));
        repeat (10) @(posedge mclk);
        arst_n <= 1'h1;
        tick(2);
        note(0, 8'h00);
        note(1, 8'h00);
        @(posedge mclk) pwm_active <= 1'h1;
        tick(1);
        // Random, full and zero duty pass straight through, one cycle late.
        // The source period starts near reset, so the random fall lands in the window.
        foreach (duty[d]) begin
            part_u.duty_hi = duty[d];
            repeat (600) begin
                p = pwm_in;
                tick(1);
                note(0, p ? fs : 8'h00);
            end
        end
        // First press with PWM active and an instant fade-in.
        fork part_u.settle(1'h0); join_none
        wait_on(1'h1);
        note(1, 8'h01);
        tick(INSTANT_CYC + 20);
        note(0, fs);
        repeat (9) begin
            tick(100);
            note(0, fs);
        end
        // A short glitch is refused; a held short cuts and then restores.
        @(posedge mclk) short_below <= 1'h1;
        repeat (SHORT_QUAL_CYC - 50) @(posedge mclk);
        short_below <= 1'h0;
        tick(5);
        note(2, 8'h00);
        @(posedge mclk) short_below <= 1'h1;
        tick(SHORT_QUAL_CYC + 5);
        note(2, 8'h01);
        note(0, 8'(fs / 5));
        @(posedge mclk) short_below <= 1'h0;
        tick(SHORT_QUAL_CYC + 5);
        note(2, 8'h00);
        note(0, fs);
        wait fork;
        part_u.settle(1'h1);
        note(1, 8'h01);
        // Second press fades out over its own setting.
        @(posedge mclk) pwm_active <= 1'h0;
        fork part_u.settle(1'h0); join_none
        wait_on(1'h0);
        note(1, 8'h00);
        tick(30 * fout);
        note(3, 8'h00);
        tick(33 * fout + 50);
        note(0, 8'h00);
        wait fork;
        part_u.settle(1'h1);
        // A slow fade-in is reversed part-way by the next press.
        @(posedge mclk) fade_in <= FADE_W'(fin);
        fork part_u.settle(1'h0); join_none
        wait_on(1'h1);
        tick(fin * 25);
        note(3, 8'h00);
        wait fork;
        part_u.settle(1'h1);
        fork part_u.settle(1'h0); join_none
        wait_on(1'h0);
        note(1, 8'h00);
        tick(10);
        note(3, 8'h00);
        tick(63 * fout);
        note(0, 8'h00);
        wait fork;
        part_u.settle(1'h1);
        note(1, 8'h00);
        tick(1);
        summarize();
    end
endmodule
`default_nettype wire
